// ==== hw/ihrp_defs.vh ====
/*
 * constants of the indexed host register port: direct and indirect
 * addresses, field positions, reset and readback values, settle counts.
 * assumes inclusion by a verilog-2005 design file of the same block.
 */
`ifndef IHRP_DEFS_VH
`define IHRP_DEFS_VH
`define IHRP_ADR_INDEX     2'h0
`define IHRP_ADR_DATA      2'h1
`define IHRP_ADR_STATUS    2'h2
`define IHRP_ADR_SAMPLE    2'h3
`define IHRP_IX_LEFT_OUT   4'h6
`define IHRP_IX_RIGHT_OUT  4'h7
`define IHRP_IX_FORMAT     4'h8
`define IHRP_IX_IFCFG      4'h9
`define IHRP_IX_PINCTL     4'hA
`define IHRP_IX_TESTINIT   4'hB
`define IHRP_IX_MISC       4'hC
`define IHRP_IX_CNT_HI     4'hE
`define IHRP_IX_CNT_LO     4'hF
`define IHRP_BIT_INIT      7
`define IHRP_BIT_MCE       6
`define IHRP_BIT_TRD       5
`define IHRP_BIT_MUTE      7
`define IHRP_BIT_PEN       0
`define IHRP_BIT_CEN       1
`define IHRP_BIT_ACI       5
`define IHRP_IFCFG_EN_MASK 8'h03
`define IHRP_INDEX_RESET   8'h40
`define IHRP_BUSY_READ     8'h80
`define IHRP_MIDSCALE      16'h0000
`define IHRP_STATUS_RESET  8'hCC
`define IHRP_SETTLE_CYCLES 128
`define IHRP_INIT_CYCLES   64
`endif

// ==== hw/ihrp_top.v ====
/*
 * host register front end: direct two-bit decode, sixteen indirect
 * registers, transfer request gating, mode change mute and settling.
 * assumes acks, sample ticks, interrupt events and adc samples arrive as
 * single-cycle pulses from logic on mclk. the host strobe, address and
 * write data pins are asynchronous to mclk and pass two stages here, so
 * the host must hold address and data steady for the whole strobe and keep
 * each strobe level for at least three mclk cycles, high and low.
 * read data follows the synchronised address one cycle later and then
 * stands until the address or the selected register changes.
 * limitation: a strobe that lands while initialization is busy is lost.
 */
`timescale 1ns/100ps
`include "ihrp_defs.vh"
`default_nettype none
module ihrp_top #(
   parameter SETTLE_CYCLES = `IHRP_SETTLE_CYCLES,
   parameter INIT_CYCLES   = `IHRP_INIT_CYCLES,
   parameter [3:0] MISC_ID = 4'hA
) (
   input  wire        mclk,
   input  wire        resetn,
   input  wire [1:0]  direct_reg_select,
   input  wire        host_wr_pin,
   input  wire        host_rd_pin,
   input  wire [7:0]  host_wdata,
   input  wire        sample_tick,
   input  wire        playback_ack,
   input  wire        capture_ack,
   input  wire        irq_event,
   input  wire [15:0] adc_sample,
   input  wire        adc_valid,
   output reg  [7:0]  host_rdata,
   output reg         playback_dma_request,
   output reg         capture_dma_request,
   output reg         irq_out,
   output reg         dac_left_mute,
   output reg         dac_right_mute,
   output reg         adc_mute,
   output reg  [15:0] dac_feed,
   output reg  [7:0]  playback_sample_byte,
   output reg         playback_byte_strobe,
   output reg  [15:0] capture_hold
);
   reg  [2:0]  wr_sync_q;
   reg  [2:0]  rd_sync_q;
   reg  [3:0]  indirect_index_q;
   reg         mode_change_allow_q;
   reg         request_block_on_irq_q;
   reg         init_busy_q;
   reg  [7:0]  init_cnt_q;
   reg  [7:0]  ind_q [0:15];
   reg         irq_flag_q;
   reg  [15:0] cur_count_q;
   reg  [8:0]  settle_cnt_q;
   reg         calibration_in_progress_q;
   reg  [7:0]  capture_sample_byte_q;
   reg         cap_upper_q;
   wire        wr_pulse;
   wire        rd_pulse;
   wire        settling;
   wire        playback_enable_bit;
   wire        capture_enable_bit;
   wire        gate_ok;
   wire        fmt_lock;
   integer     k;

   // host address and data pins, two stages each before any logic
   reg  [1:0]  adr_meta_q;
   reg  [1:0]  adr_sync_q;
   reg  [7:0]  wdata_meta_q;
   reg  [7:0]  wdata_sync_q;
   // decoded host cycles, qualified by the initialization state
   wire        host_wr_ok;
   wire        host_rd_ok;
   wire        index_wr;
   wire        status_wr;
   wire        sample_rd;
   wire        mce_exit;

   // second stage feeds the third, and both feed the edge detect
   assign wr_pulse = wr_sync_q[1] & ~wr_sync_q[2];
   assign rd_pulse = rd_sync_q[1] & ~rd_sync_q[2];
   assign playback_enable_bit      = ind_q[`IHRP_IX_IFCFG][`IHRP_BIT_PEN];
   assign capture_enable_bit      = ind_q[`IHRP_IX_IFCFG][`IHRP_BIT_CEN];
   assign settling = settle_cnt_q != 9'h000;
   assign gate_ok  = ~(request_block_on_irq_q & irq_flag_q);
   assign fmt_lock = ~mode_change_allow_q;

   // a strobe taken while busy is dropped, not deferred
   assign host_wr_ok = wr_pulse & ~init_busy_q;
   assign host_rd_ok = rd_pulse & ~init_busy_q;
   assign index_wr   = host_wr_ok & (adr_sync_q == `IHRP_ADR_INDEX);
   assign status_wr  = host_wr_ok & (adr_sync_q == `IHRP_ADR_STATUS);
   assign sample_rd  = host_rd_ok & (adr_sync_q == `IHRP_ADR_SAMPLE);
   assign mce_exit   = index_wr & mode_change_allow_q & ~wdata_sync_q[`IHRP_BIT_MCE];

   // address and data get the same two stages as the strobes, so all three
   // line up at the edge detect and no half-settled address is decoded
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_sync_q    <= 3'h0;
         rd_sync_q    <= 3'h0;
         adr_meta_q   <= 2'h0;
         adr_sync_q   <= 2'h0;
         wdata_meta_q <= 8'h00;
         wdata_sync_q <= 8'h00;
      end else begin
         wr_sync_q    <= {wr_sync_q[1:0], host_wr_pin};
         rd_sync_q    <= {rd_sync_q[1:0], host_rd_pin};
         adr_meta_q   <= direct_reg_select;
         adr_sync_q   <= adr_meta_q;
         wdata_meta_q <= host_wdata;
         wdata_sync_q <= wdata_meta_q;
      end
   end

   // initialization: bus is not answered for a while after reset
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         init_busy_q <= 1'b1;
         init_cnt_q  <= 8'h00;
      end else if (init_busy_q) begin
         init_cnt_q <= init_cnt_q + 8'h01;
         if (init_cnt_q == INIT_CYCLES[7:0] - 8'h01)
            init_busy_q <= 1'b0;
      end
   end

   // direct registers and the indirect file
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         indirect_index_q       <= 4'h0;
         mode_change_allow_q    <= 1'b1;
         request_block_on_irq_q <= 1'b0;
         for (k = 0; k < 16; k = k + 1)
            ind_q[k] <= 8'h00;
         playback_sample_byte   <= 8'h00;
         playback_byte_strobe   <= 1'b0;
      end else begin
         playback_byte_strobe <= 1'b0;
         if (host_wr_ok) begin
            case (adr_sync_q)
               `IHRP_ADR_INDEX: begin
                  indirect_index_q       <= wdata_sync_q[3:0];
                  mode_change_allow_q    <= wdata_sync_q[`IHRP_BIT_MCE];
                  request_block_on_irq_q <= wdata_sync_q[`IHRP_BIT_TRD];
               end
               `IHRP_ADR_DATA: begin
                  if (indirect_index_q == `IHRP_IX_FORMAT) begin
                     if (!fmt_lock)
                        ind_q[indirect_index_q] <= wdata_sync_q;
                  end else if (indirect_index_q == `IHRP_IX_IFCFG) begin
                     // only the two enable bits change on the fly
                     if (!fmt_lock)
                        ind_q[indirect_index_q] <= wdata_sync_q;
                     else
                        ind_q[indirect_index_q] <=
                           (ind_q[indirect_index_q] & ~`IHRP_IFCFG_EN_MASK) |
                           (wdata_sync_q & `IHRP_IFCFG_EN_MASK);
                  end else if (indirect_index_q != `IHRP_IX_MISC &&
                               indirect_index_q != `IHRP_IX_TESTINIT) begin
                     ind_q[indirect_index_q] <= wdata_sync_q;
                  end
               end
               `IHRP_ADR_SAMPLE: begin
                  playback_sample_byte <= wdata_sync_q;
                  playback_byte_strobe <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // sticky interrupt, set wins over a host clear
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         irq_flag_q <= 1'b0;
      else if (irq_event)
         irq_flag_q <= 1'b1;
      else if (status_wr)
         irq_flag_q <= 1'b0;
   end

   // current count reloads from the base bytes on underflow
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         cur_count_q <= 16'h0000;
      else if (sample_tick && (playback_enable_bit || capture_enable_bit) && gate_ok) begin
         if (cur_count_q == 16'h0000)
            cur_count_q <= {ind_q[`IHRP_IX_CNT_HI], ind_q[`IHRP_IX_CNT_LO]};
         else
            cur_count_q <= cur_count_q - 16'h0001;
      end
   end

   // pending requests finish; new ones wait for the gate
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         playback_dma_request <= 1'b0;
         capture_dma_request  <= 1'b0;
      end else begin
         if (playback_ack || !playback_enable_bit)
            playback_dma_request <= 1'b0;
         else if (sample_tick && gate_ok)
            playback_dma_request <= 1'b1;
         if (capture_ack || !capture_enable_bit)
            capture_dma_request <= 1'b0;
         else if (sample_tick && gate_ok)
            capture_dma_request <= 1'b1;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         settle_cnt_q              <= 9'h000;
         calibration_in_progress_q <= 1'b0;
      end else if (mce_exit) begin
         settle_cnt_q              <= SETTLE_CYCLES[8:0];
         calibration_in_progress_q <= 1'b1;
      end else if (settling) begin
         if (sample_tick)
            settle_cnt_q <= settle_cnt_q - 9'h001;
      end else begin
         calibration_in_progress_q <= 1'b0;
      end
   end

   // converter feed: dac midscale when starved, capture midscale when settling
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dac_feed     <= `IHRP_MIDSCALE;
         capture_hold <= `IHRP_MIDSCALE;
         adc_mute     <= 1'b0;
      end else begin
         adc_mute <= settling;
         if (!gate_ok && !playback_dma_request)
            dac_feed <= `IHRP_MIDSCALE;
         // playback bytes shift in, upper byte first
         else if (playback_byte_strobe)
            dac_feed <= {dac_feed[7:0], playback_sample_byte};
         if (settling)
            capture_hold <= `IHRP_MIDSCALE;
         else if (adc_valid && gate_ok)
            capture_hold <= adc_sample;
      end
   end

   // mute during mode change and settling
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dac_left_mute  <= 1'b1;
         dac_right_mute <= 1'b1;
         irq_out        <= 1'b0;
      end else begin
         dac_left_mute  <= mode_change_allow_q | settling |
                           ind_q[`IHRP_IX_LEFT_OUT][`IHRP_BIT_MUTE];
         dac_right_mute <= mode_change_allow_q | settling |
                           ind_q[`IHRP_IX_RIGHT_OUT][`IHRP_BIT_MUTE];
         irq_out        <= irq_flag_q & ind_q[`IHRP_IX_PINCTL][1];
      end
   end

   // capture byte sequencing: upper byte first, then the lower byte stays
   // until a new sample restarts the pointer; a new sample wins over a read
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cap_upper_q <= 1'b1;
      end else if (adc_valid) begin
         cap_upper_q <= 1'b1;
      end else if (sample_rd) begin
         cap_upper_q <= 1'b0;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         capture_sample_byte_q <= 8'h00;
      else if (cap_upper_q)
         capture_sample_byte_q <= capture_hold[15:8];
      else
         capture_sample_byte_q <= capture_hold[7:0];
   end

   // read mux, registered
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         host_rdata <= `IHRP_BUSY_READ;
      else if (init_busy_q)
         host_rdata <= `IHRP_BUSY_READ;
      else begin
         case (adr_sync_q)
            `IHRP_ADR_INDEX:
               host_rdata <= {1'b0, mode_change_allow_q, request_block_on_irq_q,
                              1'b0, indirect_index_q};
            `IHRP_ADR_DATA: begin
               if (indirect_index_q == `IHRP_IX_TESTINIT)
                  host_rdata <= {2'b00, calibration_in_progress_q, 5'h00};
               else if (indirect_index_q == `IHRP_IX_MISC)
                  host_rdata <= {4'h0, MISC_ID};
               else
                  host_rdata <= ind_q[indirect_index_q];
            end
            `IHRP_ADR_STATUS:
               host_rdata <= {cap_upper_q, 1'b1, capture_dma_request, 1'b0,
                              1'b1, 1'b1, playback_dma_request, irq_flag_q};
            `IHRP_ADR_SAMPLE:
               host_rdata <= capture_sample_byte_q;
            default:
               host_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== test/ihrp_chk.sv ====
/* port checker of ihrp_top, attached by bind below.
   assumes the top module's ports and its two count parameters only. */
`timescale 1ns/100ps
`default_nettype none
module ihrp_chk #(
   parameter SETTLE_CYCLES = 128,
   parameter INIT_CYCLES   = 64
) (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        host_wr_pin,
   input wire logic        sample_tick,
   input wire logic        playback_ack,
   input wire logic        adc_valid,
   input wire logic [7:0]  host_rdata,
   input wire logic        playback_dma_request,
   input wire logic        capture_dma_request,
   input wire logic        irq_out,
   input wire logic        dac_left_mute,
   input wire logic        dac_right_mute,
   input wire logic        adc_mute,
   input wire logic [7:0]  playback_sample_byte,
   input wire logic        playback_byte_strobe,
   input wire logic [15:0] capture_hold
);
   logic [7:0] init_q;
   logic [8:0] tick_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // margin of two cycles: the busy count start is not visible at the ports
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) init_q <= 8'h00;
      else if (init_q != 8'hFF) init_q <= init_q + 8'h01;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) tick_q <= 9'h000;
      else if (!adc_mute) tick_q <= 9'h000;
      else if (sample_tick) tick_q <= tick_q + 9'h001;
   end
   sequence wr_seen;
      $past(host_wr_pin, 3) || $past(host_wr_pin, 4) || $past(host_wr_pin, 5);
   endsequence
   sequence mute_run;
      adc_mute ##1 adc_mute;
   endsequence
   init_busy_a: assert property (init_q < INIT_CYCLES - 1 |-> host_rdata == 8'h80)
      else $error("busy readback not 80h during init");
   init_quiet_a: assert property (init_q < INIT_CYCLES - 1 |->
      !playback_dma_request && !capture_dma_request && !irq_out)
      else $error("activity during init");
   strobe_pulse_a: assert property (playback_byte_strobe |=> !playback_byte_strobe)
      else $error("playback byte strobe longer than one cycle");
   strobe_cause_a: assert property (playback_byte_strobe |-> wr_seen)
      else $error("playback byte strobe without host write");
   byte_hold_a: assert property ($changed(playback_sample_byte) |-> playback_byte_strobe)
      else $error("playback byte changed without strobe");
   ack_clear_a: assert property (playback_ack && !sample_tick |=> !playback_dma_request)
      else $error("playback request survived its ack");
   settle_mute_a: assert property (mute_run |-> $past(dac_left_mute) && $past(dac_right_mute))
      else $error("dac unmuted during settling");
   settle_len_a: assert property ($fell(adc_mute) |-> $past(tick_q) >= SETTLE_CYCLES - 1)
      else $error("settling mute ended early");
   capture_keep_a: assert property (!adc_mute && $changed(capture_hold) |-> $past(adc_valid))
      else $error("capture sample changed without new sample");
endmodule
bind ihrp_top ihrp_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .INIT_CYCLES(INIT_CYCLES)) ihrp_chk_inst (
   .mclk(mclk), .resetn(resetn), .host_wr_pin(host_wr_pin), .sample_tick(sample_tick),
   .playback_ack(playback_ack), .adc_valid(adc_valid), .host_rdata(host_rdata),
   .playback_dma_request(playback_dma_request), .capture_dma_request(capture_dma_request),
   .irq_out(irq_out), .dac_left_mute(dac_left_mute), .dac_right_mute(dac_right_mute),
   .adc_mute(adc_mute), .playback_sample_byte(playback_sample_byte),
   .playback_byte_strobe(playback_byte_strobe), .capture_hold(capture_hold));
`default_nettype wire

// ==== test/ihrp_dma_model.sv ====
/* dma controller model: acks each request with a one-cycle pulse after
   wait_cycles; assumes requests are mclk-domain levels. */
`timescale 1ns/100ps
`default_nettype none
module ihrp_dma_model (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic [3:0] wait_cycles,
   input  wire logic       playback_dma_request,
   input  wire logic       capture_dma_request,
   output var  logic       playback_ack,
   output var  logic       capture_ack
);
   logic [3:0] pb_q, cp_q;
   // ack lasts one cycle: a held ack would swallow the next request
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pb_q <= 4'h0;
         cp_q <= 4'h0;
         playback_ack <= 1'b0;
         capture_ack <= 1'b0;
      end else begin
         pb_q <= (playback_dma_request && !playback_ack) ? pb_q + 4'h1 : 4'h0;
         cp_q <= (capture_dma_request && !capture_ack) ? cp_q + 4'h1 : 4'h0;
         playback_ack <= playback_dma_request && !playback_ack && pb_q == wait_cycles;
         capture_ack <= capture_dma_request && !capture_ack && cp_q == wait_cycles;
      end
   end
endmodule
`default_nettype wire

// ==== test/ihrp_tb_top.sv ====
/* bench of ihrp_top: host bus tasks, dma model, one task per scenario.
   assumes ihrp_defs.vh on the include path; short init and settle counts. */
`timescale 1ns/100ps
`include "ihrp_defs.vh"
`default_nettype none
module ihrp_tb_top;
   localparam SETTLE = 8;
   logic       mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, irq_ev = 1'b0;
   logic       av = 1'b0, pack, cack, preq, creq, irq_o, lm, rm, am, pstb;
   logic [1:0] adr = 2'h0;
   logic [3:0] dwait = 4'h1;
   logic [7:0] wdata = 8'h00, rdata, pbyte;
   logic [15:0] adc = 16'h0000;
   int         failures = 0, checks_done = 0;
   ihrp_top #(.SETTLE_CYCLES(SETTLE), .INIT_CYCLES(16)) ihrp_top_inst (.mclk(mclk),
      .resetn(resetn), .direct_reg_select(adr), .host_wr_pin(wr), .host_rd_pin(rd),
      .host_wdata(wdata), .sample_tick(tick), .playback_ack(pack), .capture_ack(cack),
      .irq_event(irq_ev), .adc_sample(adc), .adc_valid(av), .host_rdata(rdata),
      .playback_dma_request(preq), .capture_dma_request(creq), .irq_out(irq_o),
      .dac_left_mute(lm), .dac_right_mute(rm), .adc_mute(am), .dac_feed(),
      .playback_sample_byte(pbyte), .playback_byte_strobe(pstb), .capture_hold());
   ihrp_dma_model ihrp_dma_model_inst (.mclk(mclk), .resetn(resetn), .wait_cycles(dwait),
      .playback_dma_request(preq), .capture_dma_request(creq),
      .playback_ack(pack), .capture_ack(cack));
   always #2 mclk = ~mclk;
   task automatic cyc(input int n); repeat (n) @(posedge mclk); endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {7'h00, exp}, {7'h00, got});
   endtask
   // reserved index bit always written as zero by the callers
   task automatic wr8(input logic [1:0] a, input logic [7:0] d);
      adr <= a; wdata <= d; wr <= 1'b1; cyc(4); wr <= 1'b0; cyc(6);
   endtask
   task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string what);
      logic [7:0] got;
      adr <= a; rd <= 1'b1; cyc(4); got = rdata; rd <= 1'b0; cyc(6);
      chk(what, exp, got);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin tick <= 1'b1; cyc(1); tick <= 1'b0; cyc(3); end
   endtask
   task automatic t_init;
      resetn <= 1'b1; cyc(3);
      chk("index in init", 8'h80, rdata);
      adr <= 2'h1; cyc(2);
      chk("window in init", 8'h80, rdata);
      cyc(16);
      rdc(2'h0, 8'h40, "index after init");
      chk1("left mute in mode change", 1'b1, lm);
   endtask
   task automatic t_index;
      logic [3:0] ix [4] = '{4'h6, 4'h7, 4'hE, 4'hF};
      logic [7:0] vv [4] = '{8'hA5, 8'h25, 8'h3C, 8'hC3};
      for (int i = 0; i < 4; i++) begin wr8(2'h0, {4'h4, ix[i]}); wr8(2'h1, vv[i]); end
      for (int i = 0; i < 4; i++) begin
         wr8(2'h0, {4'h4, ix[i]});
         rdc(2'h0, {4'h4, ix[i]}, "index");
         rdc(2'h1, vv[i], "window");
         rdc(2'h2, `IHRP_STATUS_RESET, "status");
         rdc(2'h1, vv[i], "window again");
      end
   endtask
   // rate fields and autocal left clear, so no special sequence is due
   task automatic t_mode;
      wr8(2'h0, 8'h48); wr8(2'h1, 8'h40); wr8(2'h0, 8'h49); wr8(2'h1, 8'h00);
      wr8(2'h0, 8'h0B);
      rdc(2'h1, 8'h20, "calibration flag set");
      chk1("adc mute settling", 1'b1, am);
      wr8(2'h0, 8'h08); wr8(2'h1, 8'h55);
      rdc(2'h1, 8'h40, "format locked");
      wr8(2'h0, 8'h09); wr8(2'h1, 8'h03);
      rdc(2'h1, 8'h03, "enables writable");
      ticks(SETTLE + 2); wr8(2'h0, 8'h0B);
      rdc(2'h1, 8'h00, "calibration flag clear");
      chk1("adc mute end", 1'b0, am);
      chk1("left mute bit", 1'b1, lm);
      chk1("right mute bit", 1'b0, rm);
   endtask
   task automatic t_dma;
      dwait <= 4'hF; wr8(2'h0, 8'h0A); wr8(2'h1, 8'h02); ticks(1);
      chk1("playback request", 1'b1, preq);
      chk1("capture request", 1'b1, creq);
      cyc(20); wr8(2'h0, 8'h2A);
      irq_ev <= 1'b1; cyc(1); irq_ev <= 1'b0; cyc(3);
      chk1("irq pin", 1'b1, irq_o);
      ticks(1);
      chk1("blocked request", 1'b0, preq);
      wr8(2'h2, 8'h00);
      chk1("irq cleared", 1'b0, irq_o);
      ticks(1);
      chk1("resumed request", 1'b1, preq);
      dwait <= 4'h0; cyc(20);
   endtask
   task automatic t_pio;
      wr8(2'h3, 8'h7E);
      chk("playback byte", 8'h7E, pbyte);
      adc <= 16'h1234; av <= 1'b1; cyc(1); av <= 1'b0; cyc(2);
      rdc(2'h3, 8'h12, "capture upper");
      rdc(2'h3, 8'h34, "capture lower");
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      cyc(20);
      t_init; t_index; t_mode; t_dma; t_pio;
      end_of_test;
   end
   initial begin
      cyc(6000);
      failures++;
      end_of_test;
   end
endmodule
`default_nettype wire
